/* File: hdl/etpsio_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Two event inputs, time tagged finely
// - Software sets each input's edge polarity
// - Alignment source pulses realign the time base
// - Alignment lag held within 15 to 50 ns
// - 10 MHz reference, internal or external
// - Software sets pulse polarity, rate, width
// - Default pulse width is 5 ms
// - Startup: high 1 ms, float, then inactive
// - Ready rises about 300 ms after power
// - Ready high operating, low standby or reset
// - Two general outputs set by command
// - General outputs float during early boot
// - Three lamps, active high
// - Lamp levels valid only after boot
module etpsio_top #(
    parameter int unsigned GLITCH_CYCLES   = etpsio_pkg::GLITCH_CYC,
    parameter int unsigned READY_CYCLES    = etpsio_pkg::READY_CYC,
    parameter int unsigned BOOT_CYCLES     = etpsio_pkg::BOOT_CYC,
    parameter int unsigned TICKS_PER_SEC   = etpsio_pkg::REF_TICKS_SEC,
    parameter int unsigned TICKS_PER_MS    = etpsio_pkg::REF_TICKS_MS
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          eventInputFirst,
    input  wire logic                          eventInputSecond,
    input  wire logic                          refSelExternal,
    input  wire logic                          refExternalPin,
    input  wire logic                          standbyReq,
    input  wire logic                          eventCfgValid,
    input  wire logic                          eventCfgChan,
    input  wire logic                          eventCfgEnable,
    input  wire logic                          eventCfgActiveLow,
    input  wire logic                          alignSrcValid,
    input  wire logic [1:0]                    alignSrcSel,
    input  wire logic                          ppsCfgValid,
    input  wire logic                          ppsCfgActiveLow,
    input  wire logic [etpsio_pkg::PER_W-1:0]  ppsCfgPeriodSec,
    input  wire logic [etpsio_pkg::WID_W-1:0]  ppsCfgWidthMs,
    input  wire logic                          gpCmdValid,
    input  wire logic [1:0]                    gpCmdLevel,
    input  wire logic                          lampCmdValid,
    input  wire logic [2:0]                    lampCmdLevel,
    output logic                               evtValid,
    output logic                               evtSource,
    output logic [etpsio_pkg::SEC_W-1:0]       evtSeconds,
    output logic [etpsio_pkg::TICK_W-1:0]      evtTicks,
    output logic [etpsio_pkg::PHASE_W-1:0]     evtPhase,
    output logic                               secondPulseOut,
    output logic                               secondPulseOe,
    output logic                               generalOutputOne,
    output logic                               generalOutputTwo,
    output logic                               generalOutputOe,
    output logic                               statusLampOne,
    output logic                               statusLampTwo,
    output logic                               loggingLamp,
    output logic                               moduleReady,
    output logic                               bootDone
);
    import etpsio_pkg::*;

    // Channel mask of the alignment source; used for tagging and aligning
    function automatic logic [N_EVT-1:0] alignMask(etpsio_align_t sel);
        alignMask = {sel == ALIGN_SECOND, sel == ALIGN_FIRST};
    endfunction

    logic [N_EVT-1:0]   evtPin;
    logic [N_EVT-1:0]   evtHit;
    logic [N_EVT-1:0]   tagHit;
    logic               alignHit;
    logic               refRise;
    logic               refTick;
    logic               msTick;
    logic               secEdge;
    logic               halfPast;
    // Configuration
    logic [N_EVT-1:0]   evtEnable_ff, nxt_evtEnable;
    logic [N_EVT-1:0]   evtActLo_ff, nxt_evtActLo;
    etpsio_align_t      alignSel_ff, nxt_alignSel;
    logic               ppsActLo_ff, nxt_ppsActLo;
    logic [PER_W-1:0]   ppsPeriod_ff, nxt_ppsPeriod;
    logic [WID_W-1:0]   ppsWidth_ff, nxt_ppsWidth;
    logic [1:0]         gpLevel_ff, nxt_gpLevel;
    logic [2:0]         lamp_ff, nxt_lamp;
    // Time base
    logic [PHASE_W-1:0] phase_ff, nxt_phase;
    logic [TICK_W-1:0]  ticks_ff, nxt_ticks;
    logic [MS_W-1:0]    msCnt_ff, nxt_msCnt;
    logic [SEC_W-1:0]   sec_ff, nxt_sec;
    // Pulse generator
    logic [PER_W-1:0]   perCnt_ff, nxt_perCnt;
    logic [WID_W-1:0]   widCnt_ff, nxt_widCnt;
    logic               ppsAct_ff, nxt_ppsAct;
    // Startup sequencer
    etpsio_boot_t       boot_ff, nxt_boot;
    logic [31:0]        bootCnt_ff, nxt_bootCnt;
    logic               ready_ff, nxt_ready;
    logic               ppsPin_ff, nxt_ppsPin;
    logic               ppsOe_ff, nxt_ppsOe;
    logic               gpOe_ff, nxt_gpOe;
    // Event report
    logic [N_EVT-1:0]   holdV_ff, nxt_holdV;
    logic [SEC_W-1:0]   holdSec_ff [N_EVT];
    logic [SEC_W-1:0]   nxt_holdSec [N_EVT];
    logic [TICK_W-1:0]  holdTick_ff [N_EVT];
    logic [TICK_W-1:0]  nxt_holdTick [N_EVT];
    logic [PHASE_W-1:0] holdPh_ff [N_EVT];
    logic [PHASE_W-1:0] nxt_holdPh [N_EVT];
    logic               evtV_ff, nxt_evtV;
    logic               evtSrc_ff, nxt_evtSrc;
    logic [SEC_W-1:0]   evtSec_ff, nxt_evtSec;
    logic [TICK_W-1:0]  evtTick_ff, nxt_evtTick;
    logic [PHASE_W-1:0] evtPh_ff, nxt_evtPh;

    assign evtPin = {eventInputSecond, eventInputFirst};

    // Per-input synchronizer and edge selection
    genvar g;
    generate
        for (g = 0; g < N_EVT; g++) begin : gEvt
            etpsio_edge_sync uSync (
                .clk       (clk),
                .rst       (rst),
                .pin       (evtPin[g]),
                .activeLow (evtActLo_ff[g]),
                .edgeHit   (evtHit[g])
            );
        end
    endgenerate

    // External reference is sampled like any pin; rising edge is a tick
    etpsio_edge_sync uRefSync (
        .clk       (clk),
        .rst       (rst),
        .pin       (refExternalPin),
        .activeLow (1'b0),
        .edgeHit   (refRise)
    );

    // An input chosen as alignment source is not tagged
    assign tagHit   = evtHit & evtEnable_ff & ~alignMask(alignSel_ff);
    assign alignHit = |(evtHit & alignMask(alignSel_ff));

    // Configuration commands; an undefined source code means none
    always_comb begin
        nxt_evtEnable = evtEnable_ff;
        nxt_evtActLo  = evtActLo_ff;
        nxt_alignSel  = alignSel_ff;
        nxt_ppsActLo  = ppsActLo_ff;
        nxt_ppsPeriod = ppsPeriod_ff;
        nxt_ppsWidth  = ppsWidth_ff;
        nxt_gpLevel   = gpLevel_ff;
        nxt_lamp      = lamp_ff;
        if (eventCfgValid) begin
            nxt_evtEnable[eventCfgChan] = eventCfgEnable;
            nxt_evtActLo[eventCfgChan]  = eventCfgActiveLow;
        end
        if (alignSrcValid) begin
            nxt_alignSel = (alignSrcSel == 2'h3) ? ALIGN_NONE
                                                 : etpsio_align_t'(alignSrcSel);
        end
        if (ppsCfgValid) begin
            nxt_ppsActLo  = ppsCfgActiveLow;
            nxt_ppsPeriod = ppsCfgPeriodSec;
            nxt_ppsWidth  = ppsCfgWidthMs;
        end
        if (gpCmdValid) begin
            nxt_gpLevel = gpCmdLevel;
        end
        if (lampCmdValid) begin
            nxt_lamp = lampCmdLevel;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            evtEnable_ff <= EVT_ENABLE_RST;
            evtActLo_ff  <= EVT_ACTIVE_LO_RST;
            alignSel_ff  <= ALIGN_NONE;
            ppsActLo_ff  <= PPS_ACTIVE_LO_RST;
            ppsPeriod_ff <= PPS_PERIOD_RST;
            ppsWidth_ff  <= PPS_WIDTH_RST;
            gpLevel_ff   <= GP_LEVEL_RST;
            lamp_ff      <= LAMP_RST;
        end else begin
            evtEnable_ff <= nxt_evtEnable;
            evtActLo_ff  <= nxt_evtActLo;
            alignSel_ff  <= nxt_alignSel;
            ppsActLo_ff  <= nxt_ppsActLo;
            ppsPeriod_ff <= nxt_ppsPeriod;
            ppsWidth_ff  <= nxt_ppsWidth;
            gpLevel_ff   <= nxt_gpLevel;
            lamp_ff      <= nxt_lamp;
        end
    end

    // Reference tick: internal divider or external edge
    assign refTick  = refSelExternal ? refRise
                    : (phase_ff == PHASE_W'(CLK_PER_REF - 1));
    assign msTick   = refTick && (msCnt_ff == MS_W'(TICKS_PER_MS - 1));
    assign halfPast = ticks_ff >= TICK_W'(TICKS_PER_SEC / 2);
    // An early alignment pulse counts as the next second, a late one not
    assign secEdge  = alignHit ? halfPast
                    : refTick && (ticks_ff == TICK_W'(TICKS_PER_SEC - 1));

    // Time base; phase saturates if an external reference stalls
    always_comb begin
        nxt_phase = (phase_ff == {PHASE_W{1'b1}}) ? phase_ff
                                                  : phase_ff + 1'b1;
        nxt_ticks = ticks_ff;
        nxt_msCnt = msCnt_ff;
        nxt_sec   = sec_ff;
        if (refTick) begin
            nxt_phase = '0;
            nxt_ticks = ticks_ff + 1'b1;
            nxt_msCnt = msTick ? '0 : msCnt_ff + 1'b1;
        end
        if (secEdge) begin
            nxt_ticks = '0;
            nxt_sec   = sec_ff + 1'b1;
        end
        // Preload the sync latency so the lag stays inside the window
        if (alignHit) begin
            nxt_phase = PHASE_W'(ALIGN_COMP_CYC);
            nxt_ticks = '0;
            nxt_msCnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_ff <= '0;
            ticks_ff <= '0;
            msCnt_ff <= '0;
            sec_ff   <= '0;
        end else begin
            phase_ff <= nxt_phase;
            ticks_ff <= nxt_ticks;
            msCnt_ff <= nxt_msCnt;
            sec_ff   <= nxt_sec;
        end
    end

    // Pulse every ppsPeriod seconds, ppsWidth ms long; period 0 acts as 1
    always_comb begin
        nxt_perCnt = perCnt_ff;
        nxt_widCnt = widCnt_ff;
        nxt_ppsAct = ppsAct_ff;
        if (ppsAct_ff && msTick) begin
            nxt_widCnt = widCnt_ff + 1'b1;
            if (widCnt_ff + 1'b1 >= ppsWidth_ff) begin
                nxt_ppsAct = 1'b0;
            end
        end
        if (secEdge) begin
            if (perCnt_ff + 1'b1 >= ppsPeriod_ff) begin
                nxt_perCnt = '0;
                nxt_widCnt = '0;
                nxt_ppsAct = 1'b1;
            end else begin
                nxt_perCnt = perCnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            perCnt_ff <= '0;
            widCnt_ff <= '0;
            ppsAct_ff <= 1'b0;
        end else begin
            perCnt_ff <= nxt_perCnt;
            widCnt_ff <= nxt_widCnt;
            ppsAct_ff <= nxt_ppsAct;
        end
    end

    // Startup sequencer; counter stops once the run state is reached
    always_comb begin
        nxt_bootCnt = (bootCnt_ff == 32'(BOOT_CYCLES - 1)) ? bootCnt_ff
                                                          : bootCnt_ff + 1;
        nxt_boot    = boot_ff;
        case (boot_ff)
            ST_GLITCH: begin
                if (bootCnt_ff == 32'(GLITCH_CYCLES - 1)) begin
                    nxt_boot = ST_FLOAT;
                end
            end
            ST_FLOAT: begin
                if (bootCnt_ff == 32'(BOOT_CYCLES - 1)) begin
                    nxt_boot = ST_RUN;
                end
            end
            ST_RUN: begin
                nxt_boot = ST_RUN;
            end
            default: begin
                nxt_boot = ST_GLITCH;
            end
        endcase
        nxt_ready = !standbyReq
                 && (bootCnt_ff >= 32'(READY_CYCLES - 1));
        // Pin drive follows the next state so output and state agree
        nxt_ppsOe  = (nxt_boot != ST_FLOAT);
        nxt_ppsPin = (nxt_boot == ST_GLITCH) ? 1'b1
                   : (nxt_boot == ST_RUN) && (nxt_ppsAct ^ nxt_ppsActLo);
        nxt_gpOe   = (nxt_boot == ST_RUN);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            boot_ff    <= ST_GLITCH;
            bootCnt_ff <= 32'h0000_0000;
            ready_ff   <= 1'b0;
            ppsPin_ff  <= 1'b1;
            ppsOe_ff   <= 1'b1;
            gpOe_ff    <= 1'b0;
        end else begin
            boot_ff    <= nxt_boot;
            bootCnt_ff <= nxt_bootCnt;
            ready_ff   <= nxt_ready;
            ppsPin_ff  <= nxt_ppsPin;
            ppsOe_ff   <= nxt_ppsOe;
            gpOe_ff    <= nxt_gpOe;
        end
    end

    // Each input holds one tag; inputs are spaced far apart so one
    // slot each never overflows. First input reports first.
    always_comb begin
        nxt_holdV    = holdV_ff;
        nxt_holdSec  = holdSec_ff;
        nxt_holdTick = holdTick_ff;
        nxt_holdPh   = holdPh_ff;
        nxt_evtV     = 1'b0;
        nxt_evtSrc   = evtSrc_ff;
        nxt_evtSec   = evtSec_ff;
        nxt_evtTick  = evtTick_ff;
        nxt_evtPh    = evtPh_ff;
        for (int i = 0; i < N_EVT; i++) begin
            if (holdV_ff[i] && !nxt_evtV) begin
                nxt_evtV     = 1'b1;
                nxt_evtSrc   = 1'(i);
                nxt_evtSec   = holdSec_ff[i];
                nxt_evtTick  = holdTick_ff[i];
                nxt_evtPh    = holdPh_ff[i];
                nxt_holdV[i] = 1'b0;
            end
        end
        // A new capture beats the clear of its slot
        for (int i = 0; i < N_EVT; i++) begin
            if (tagHit[i]) begin
                nxt_holdV[i]    = 1'b1;
                nxt_holdSec[i]  = sec_ff;
                nxt_holdTick[i] = ticks_ff;
                nxt_holdPh[i]   = phase_ff;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            holdV_ff    <= '0;
            holdSec_ff  <= '{default: '0};
            holdTick_ff <= '{default: '0};
            holdPh_ff   <= '{default: '0};
            evtV_ff     <= 1'b0;
            evtSrc_ff   <= 1'b0;
            evtSec_ff   <= '0;
            evtTick_ff  <= '0;
            evtPh_ff    <= '0;
        end else begin
            holdV_ff    <= nxt_holdV;
            holdSec_ff  <= nxt_holdSec;
            holdTick_ff <= nxt_holdTick;
            holdPh_ff   <= nxt_holdPh;
            evtV_ff     <= nxt_evtV;
            evtSrc_ff   <= nxt_evtSrc;
            evtSec_ff   <= nxt_evtSec;
            evtTick_ff  <= nxt_evtTick;
            evtPh_ff    <= nxt_evtPh;
        end
    end

    // Outputs; lamps read as lit when high
    assign evtValid         = evtV_ff;
    assign evtSource        = evtSrc_ff;
    assign evtSeconds       = evtSec_ff;
    assign evtTicks         = evtTick_ff;
    assign evtPhase         = evtPh_ff;
    assign secondPulseOut   = ppsPin_ff;
    assign secondPulseOe    = ppsOe_ff;
    assign generalOutputOne = gpLevel_ff[0];
    assign generalOutputTwo = gpLevel_ff[1];
    assign generalOutputOe  = gpOe_ff;
    assign statusLampOne    = lamp_ff[0];
    assign statusLampTwo    = lamp_ff[1];
    assign loggingLamp      = lamp_ff[2];
    assign moduleReady      = ready_ff;
    assign bootDone         = (boot_ff == ST_RUN);

    property p_ready_early;
        @(posedge clk) disable iff (rst)
        (bootCnt_ff < 32'(READY_CYCLES - 1)) |=> !moduleReady;
    endproperty
    a_ready_early: assert property (p_ready_early)
        else $error("ready raised before its delay");

    property p_ready_standby;
        @(posedge clk) disable iff (rst)
        standbyReq |=> !moduleReady ##0 (bootCnt_ff >= 32'(1));
    endproperty
    a_ready_standby: assert property (p_ready_standby)
        else $error("ready high during standby");

    property p_glitch_high;
        @(posedge clk) disable iff (rst)
        (boot_ff == ST_GLITCH) |-> secondPulseOe && secondPulseOut;
    endproperty
    a_glitch_high: assert property (p_glitch_high)
        else $error("pulse pin not driven high at startup");

    property p_float_z;
        @(posedge clk) disable iff (rst)
        $rose(boot_ff == ST_FLOAT) |-> !secondPulseOe
            && ($past(bootCnt_ff) == 32'(GLITCH_CYCLES - 1));
    endproperty
    a_float_z: assert property (p_float_z)
        else $error("pulse pin float entered at wrong time");

    property p_gp_float;
        @(posedge clk) disable iff (rst)
        !bootDone |-> !generalOutputOe;
    endproperty
    a_gp_float: assert property (p_gp_float)
        else $error("general outputs driven during boot");

    property p_pps_width;
        @(posedge clk) disable iff (rst)
        (ppsAct_ff && msTick && !secEdge
            && (widCnt_ff + 1'b1 < ppsWidth_ff)) |=> ppsAct_ff;
    endproperty
    a_pps_width: assert property (p_pps_width)
        else $error("pulse ended before programmed width");

    property p_pps_level;
        @(posedge clk) disable iff (rst)
        bootDone |-> secondPulseOe
            && (secondPulseOut == (ppsAct_ff ^ ppsActLo_ff));
    endproperty
    a_pps_level: assert property (p_pps_level)
        else $error("pulse pin level disagrees with polarity");

    property p_tag_first;
        @(posedge clk) disable iff (rst)
        tagHit[0] |-> ##2 (evtValid && !evtSource
            && evtSeconds == $past(sec_ff, 2));
    endproperty
    a_tag_first: assert property (p_tag_first)
        else $error("first input capture not reported");

    property p_align;
        @(posedge clk) disable iff (rst)
        alignHit |=> (phase_ff == PHASE_W'(ALIGN_COMP_CYC))
            && (ticks_ff == '0) && !$past(tagHit[0] && alignSel_ff
            == ALIGN_FIRST);
    endproperty
    a_align: assert property (p_align)
        else $error("time base not realigned by alignment pulse");

    property p_gp_level;
        @(posedge clk) disable iff (rst)
        gpCmdValid |=> {generalOutputTwo, generalOutputOne}
            == $past(gpCmdLevel);
    endproperty
    a_gp_level: assert property (p_gp_level)
        else $error("general output level not applied");

endmodule
`default_nettype wire

/* File: hdl/etpsio_pkg.sv */
package etpsio_pkg;

    // Clocking and reference
    localparam int unsigned CLK_FREQ_HZ   = 40_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
    localparam int unsigned REF_FREQ_HZ   = 10_000_000;
    localparam int unsigned CLK_PER_REF   = CLK_FREQ_HZ / REF_FREQ_HZ;
    localparam int unsigned REF_TICKS_SEC = REF_FREQ_HZ;
    localparam int unsigned REF_TICKS_MS  = REF_FREQ_HZ / 1000;

    // Alignment lag window; compensation rounds the longest lag down
    localparam int unsigned ALIGN_LAG_MIN_NS = 15;
    localparam int unsigned ALIGN_LAG_MAX_NS = 50;
    localparam int unsigned ALIGN_COMP_CYC   =
        ALIGN_LAG_MAX_NS / CLK_PERIOD_NS;

    // Startup timing
    localparam int unsigned GLITCH_TIME_US = 1000;
    localparam int unsigned READY_TIME_MS  = 300;
    localparam int unsigned BOOT_TIME_MS   = 3000;
    localparam int unsigned GLITCH_CYC =
        GLITCH_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int unsigned READY_CYC =
        READY_TIME_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned BOOT_CYC =
        BOOT_TIME_MS * (CLK_FREQ_HZ / 1000);

    // Field widths
    localparam int unsigned N_EVT   = 2;
    localparam int unsigned SEC_W   = 32;
    localparam int unsigned TICK_W  = 24;
    localparam int unsigned PHASE_W = 2;
    localparam int unsigned MS_W    = 14;
    localparam int unsigned PER_W   = 8;
    localparam int unsigned WID_W   = 10;

    // Values after reset
    localparam logic [N_EVT-1:0] EVT_ENABLE_RST    = 2'h3;
    localparam logic [N_EVT-1:0] EVT_ACTIVE_LO_RST = 2'h0;
    localparam logic             PPS_ACTIVE_LO_RST = 1'b0;
    localparam logic [PER_W-1:0] PPS_PERIOD_RST    = 8'h01;
    localparam logic [WID_W-1:0] PPS_WIDTH_RST     = 10'h005;
    localparam logic [1:0]       GP_LEVEL_RST      = 2'h0;
    localparam logic [2:0]       LAMP_RST          = 3'h0;

    typedef enum logic [1:0] {
        ALIGN_NONE   = 2'h0,
        ALIGN_FIRST  = 2'h1,
        ALIGN_SECOND = 2'h2
    } etpsio_align_t;

    typedef enum logic [2:0] {
        ST_GLITCH = 3'h1,
        ST_FLOAT  = 3'h2,
        ST_RUN    = 3'h4
    } etpsio_boot_t;

endpackage

/* File: hdl/etpsio_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module etpsio_edge_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    input  wire logic activeLow,
    output logic      edgeHit
);
    logic syncA_ff;
    logic syncB_ff;
    logic syncC_ff;
    logic nxt_syncA;
    logic nxt_syncB;
    logic nxt_syncC;

    // Two stages guard against metastability; syncB and syncC are decoded
    always_comb begin
        nxt_syncA = pin;
        nxt_syncB = syncA_ff;
        nxt_syncC = syncB_ff;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            syncA_ff <= 1'b0;
            syncB_ff <= 1'b0;
            syncC_ff <= 1'b0;
        end else begin
            syncA_ff <= nxt_syncA;
            syncB_ff <= nxt_syncB;
            syncC_ff <= nxt_syncC;
        end
    end

    // Selected edge: rising unless activeLow asks for falling
    assign edgeHit = (syncB_ff ^ activeLow) & ~(syncC_ff ^ activeLow);

endmodule
`default_nettype wire

/* File: testbench/etpsio_event_src.sv */
`timescale 1ns/1ps
`default_nettype none
// External event source; pins idle low like the pull-down
module etpsio_event_src (
    input  wire logic clk,
    output logic      pinFirst,
    output logic      pinSecond
);
    initial begin
        pinFirst = 1'b0;
        pinSecond = 1'b0;
    end
    // Waits out the scaled 5 ms gap first, so the rate cap holds too
    task automatic fire(input int ch);
        repeat (200) @(negedge clk);
        if (ch == 0) pinFirst = 1'b1;
        else pinSecond = 1'b1;
        repeat (4) @(negedge clk);
        pinFirst = 1'b0;
        pinSecond = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: testbench/etpsio_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module etpsio_top_test;
    logic       clk = 1'b0, rst = 1'b1, standbyReq = 1'b0;
    logic       eventInputFirst, eventInputSecond, eventCfgValid = 1'b0;
    logic       eventCfgChan = 1'b0, eventCfgEnable = 1'b1;
    logic       eventCfgActiveLow = 1'b0, ppsCfgValid = 1'b0;
    logic       ppsCfgActiveLow = 1'b0, gpCmdValid = 1'b0;
    logic       lampCmdValid = 1'b0, evtValid, evtSource;
    logic       secondPulseOut, secondPulseOe, generalOutputOne;
    logic       generalOutputTwo, generalOutputOe, statusLampOne;
    logic       statusLampTwo, loggingLamp, moduleReady, bootDone;
    logic       refSelExternal = 1'b0, refExternalPin = 1'b0;
    logic       alignSrcValid = 1'b0;
    logic [1:0] gpCmdLevel = 2'h0, alignSrcSel = 2'h1, evtPhase;
    logic [7:0] ppsCfgPeriodSec = 8'h01;
    logic [23:0] evtTicks;
    logic [31:0] evtSeconds;
    logic [2:0] lampCmdLevel = 3'h0;
    logic [9:0] ppsCfgWidthMs = 10'h005;
    int         err_total = 0, cmp_count = 0, n;
    // Short startup counts; a second is 400 clocks, a ms 40
    etpsio_top #(.GLITCH_CYCLES(8), .READY_CYCLES(20), .BOOT_CYCLES(40),
        .TICKS_PER_SEC(100), .TICKS_PER_MS(10)) i_etpsio_top (
        .clk, .rst, .eventInputFirst, .eventInputSecond,
        .refSelExternal, .refExternalPin, .standbyReq,
        .eventCfgValid, .eventCfgChan, .eventCfgEnable, .eventCfgActiveLow,
        .alignSrcValid, .alignSrcSel, .ppsCfgValid,
        .ppsCfgActiveLow, .ppsCfgPeriodSec, .ppsCfgWidthMs,
        .gpCmdValid, .gpCmdLevel, .lampCmdValid, .lampCmdLevel, .evtValid,
        .evtSource, .evtSeconds, .evtTicks, .evtPhase, .secondPulseOut,
        .secondPulseOe, .generalOutputOne, .generalOutputTwo,
        .generalOutputOe, .statusLampOne, .statusLampTwo, .loggingLamp,
        .moduleReady, .bootDone);
    etpsio_event_src i_etpsio_event_src (.clk, .pinFirst(eventInputFirst),
        .pinSecond(eventInputSecond));
    initial forever #12.5 clk = ~clk;
    // External 10 MHz reference: one rising edge every 4 clocks
    initial forever #50 refExternalPin = ~refExternalPin;
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Startup phases at scaled counts: glitch, float, ready, run
    task automatic t_boot();
        cyc(3);
        chk("glitch", 8'h03, {secondPulseOut, secondPulseOe});
        chk("gpOe", 8'h00, generalOutputOe);
        chk("rdyEarly", 8'h00, moduleReady);
        chk("gated", 8'h00, moduleReady & secondPulseOut);
        cyc(10);
        chk("float", 8'h00, secondPulseOe);
        cyc(10);
        chk("rdy", 8'h01, moduleReady);
        cyc(20);
        chk("run", 8'h0F, {bootDone, generalOutputOe, secondPulseOe,
            ~secondPulseOut});
        $display("boot test end");
    endtask
    // Output and lamp commands with one-cycle answer
    task automatic t_cmd();
        for (int i = 0; i < 4; i++) begin
            gpCmdLevel = 2'(i);
            lampCmdLevel = 3'h5 ^ 3'(i);
            gpCmdValid = 1'b1;
            lampCmdValid = 1'b1;
            cyc(1);
            gpCmdValid = 1'b0;
            lampCmdValid = 1'b0;
            cyc(1);
            chk("gp", 8'(i), {generalOutputTwo, generalOutputOne});
            chk("lamp", 8'(3'h5 ^ 3'(i)), {loggingLamp, statusLampTwo,
                statusLampOne});
        end
        $display("command test end");
    endtask
    // Waits a bounded span for a report; returns the source or 2 if none
    task automatic wait_evt(output logic [7:0] s);
        s = 8'h02;
        for (int i = 0; i < 30 && s == 8'h02; i++) begin
            if (evtValid === 1'b1) s = 8'(evtSource);
            cyc(1);
        end
    endtask
    task automatic cfg_evt(input logic ch, en, lo);
        {eventCfgChan, eventCfgEnable, eventCfgActiveLow} = {ch, en, lo};
        eventCfgValid = 1'b1;
        cyc(1);
        eventCfgValid = 1'b0;
    endtask
    // Rising edge tags first input; falling-only second; disabled first
    task automatic t_evt();
        logic [7:0] s;
        i_etpsio_event_src.fire(0);
        wait_evt(s);
        chk("evtA", 8'h00, s);
        chk("evtSec", 16'h0000, evtSeconds[15:0]);
        cfg_evt(1'b1, 1'b1, 1'b1);
        i_etpsio_event_src.fire(1);
        wait_evt(s);
        chk("evtBfall", 8'h01, s);
        cfg_evt(1'b0, 1'b0, 1'b0);
        i_etpsio_event_src.fire(0);
        wait_evt(s);
        chk("evtOff", 8'h02, s);
        $display("event test end");
    endtask
    // Align on the first input; the base restarts at phase 2, so the
    // second input's fall 208 clocks on reads tick 52, phase 1
    task automatic t_sync();
        logic [7:0] s;
        cfg_evt(1'b0, 1'b1, 1'b0);
        alignSrcValid = 1'b1;
        cyc(1);
        alignSrcValid = 1'b0;
        i_etpsio_event_src.fire(0);
        i_etpsio_event_src.fire(1);
        wait_evt(s);
        chk("syncSrc", 16'h01, s);
        chk("syncTag", 16'h00D1, {evtTicks[13:0], evtPhase});
        $display("sync test end");
    endtask
    // External reference, period 2 s: 5 ms = 200 clocks high, 600 low;
    // then a pulse under active-low polarity reads low
    task automatic t_pps();
        refSelExternal = 1'b1;
        ppsCfgPeriodSec = 8'h02;
        ppsCfgValid = 1'b1;
        cyc(1);
        ppsCfgValid = 1'b0;
        for (n = 0; secondPulseOut !== 1'b0 && n < 999; n++) cyc(1);
        for (n = 0; secondPulseOut !== 1'b1 && n < 999; n++) cyc(1);
        for (n = 0; secondPulseOut === 1'b1 && n < 999; n++) cyc(1);
        chk("width", 16'd200, 16'(n));
        for (n = 0; secondPulseOut === 1'b0 && n < 999; n++) cyc(1);
        chk("gap", 16'd600, 16'(n));
        ppsCfgActiveLow = 1'b1;
        ppsCfgValid = 1'b1;
        cyc(1);
        ppsCfgValid = 1'b0;
        cyc(2);
        chk("actLo", 16'h00, secondPulseOut);
        $display("pulse test end");
    endtask
    task automatic t_sby();
        standbyReq = 1'b1;
        cyc(2);
        chk("sby", 8'h00, moduleReady);
        standbyReq = 1'b0;
        cyc(2);
        chk("wake", 8'h01, moduleReady);
        $display("standby test end");
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        cyc(8000);
        err_total++;
        wrap_up();
    end
    initial begin
        cyc(5);
        rst = 1'b0;
        t_boot();
        t_cmd();
        t_evt();
        t_sync();
        t_pps();
        t_sby();
        wrap_up();
    end
endmodule
`default_nettype wire
